// ---- hw/swpc_pkg.sv ----
// Package for the sleep and wake power controller.
// Assumes one 200 MHz clock and a plain register port.
package swpc_pkg;
  localparam int          CLK_MHZ          = 200;
  localparam int          HOLD_MS          = 4000;
  localparam int          HOLD_CYCLES      = HOLD_MS * 1000 * CLK_MHZ;
  localparam logic [3:0]  ADDR_CTRL        = 4'h0;
  localparam logic [3:0]  ADDR_STATE       = 4'h4;
  localparam logic [3:0]  ADDR_WAKE        = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_STAT    = 4'hc;
  localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h1;
  localparam int          CTRL_SLEEP_REQ   = 0;
  localparam int          CTRL_OFF_REQ     = 1;
  localparam int          CTRL_PME_EN      = 2;
  localparam int          CTRL_S5_WAKE_EN  = 3;
  localparam int          CTRL_POLICY_LSB  = 4;
  localparam int          CTRL_DUAL_LED    = 6;
  localparam int          CTRL_S1          = 8;
  localparam int          CTRL_S3          = 9;
  localparam int          CTRL_S4          = 10;
  localparam int          CTRL_RING_UNMASK = 11;
  localparam logic [1:0]  POLICY_LAST      = 2'h0;
  localparam logic [1:0]  POLICY_ON        = 2'h1;
  localparam logic [1:0]  POLICY_OFF       = 2'h2;
  localparam int          WAKE_RING        = 0;
  localparam int          WAKE_USB         = 1;
  localparam int          WAKE_PS2         = 2;
  localparam int          WAKE_PME         = 3;
  localparam int          WAKE_LAN         = 4;
  localparam int          WAKE_BTN         = 5;
  localparam int          NWAKE            = 6;
  localparam int          IRQ_WAKE         = 0;
  localparam int          IRQ_FAILSAFE     = 1;
  localparam int          IRQ_RESTORE      = 2;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  typedef enum logic [2:0] {
    SWPC_S0     = 3'b000,
    SWPC_S1     = 3'b001,
    SWPC_S3     = 3'b011,
    SWPC_S4     = 3'b100,
    SWPC_S5     = 3'b101,
    SWPC_MECH   = 3'b111
  } swpc_state_type;
endpackage

// ---- hw/swpc_top.sv ----
// Sleep state tracker, wake collector and supply control.
// Assumes synchronous inputs and a single-cycle register port master.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module swpc_top #(
  parameter int HOLD_CYCLES = swpc_pkg::HOLD_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        main_pwr_good_i,
  input  wire logic        standby_present_i,
  input  wire logic        ring_ext_i,
  input  wire logic        ring_int_i,
  input  wire logic        usb_activity_i,
  input  wire logic        ps2_activity_i,
  input  wire logic        pme_n_i,
  input  wire logic        lan_wake_i,
  input  wire logic        pwr_button_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             supply_on_o,
  output logic             cpu_fan_on_o,
  output logic             chassis_fan_on_o,
  output logic             led_green_o,
  output logic             led_amber_o,
  output logic             standby_led_o,
  output logic             irq_o
);
  swpc_pkg::swpc_state_type state_reg;
  swpc_pkg::swpc_state_type state_next;
  logic [31:0]              ctrl_reg;
  logic [swpc_pkg::NWAKE-1:0] wake_reg;
  logic [swpc_pkg::NWAKE-1:0] wake_raw;
  logic [swpc_pkg::NWAKE-1:0] wake_en;
  logic [2:0]               irq_stat_reg;
  logic [2:0]               irq_mask_reg;
  logic [2:0]               irq_set;
  logic                     was_on_reg;
  logic                     pg_reg;
  logic                     btn_reg;
  logic [31:0]              hold_cnt_reg;
  logic                     failsafe;
  logic                     btn_short;
  logic                     wake_any;
  logic                     sleeping;
  logic                     in_s1s3;
  logic                     in_s5ish;
  logic                     pwr_lost;
  logic                     pwr_back;
  logic [1:0]               policy;

  assign policy   = ctrl_reg[swpc_pkg::CTRL_POLICY_LSB +: 2];
  assign sleeping = state_reg != swpc_pkg::SWPC_S0;
  assign in_s1s3  = state_reg == swpc_pkg::SWPC_S1 ||
                    state_reg == swpc_pkg::SWPC_S3;
  assign in_s5ish = state_reg == swpc_pkg::SWPC_S5 ||
                    state_reg == swpc_pkg::SWPC_MECH;
  assign pwr_lost = pg_reg && !main_pwr_good_i;
  assign pwr_back = !pg_reg && main_pwr_good_i;

  // Raw sources; ring lines are merged so either modem type counts
  always_comb
  begin
    wake_raw = '0;
    wake_raw[swpc_pkg::WAKE_RING] = ring_ext_i | ring_int_i;
    wake_raw[swpc_pkg::WAKE_USB]  = usb_activity_i;
    wake_raw[swpc_pkg::WAKE_PS2]  = ps2_activity_i;
    wake_raw[swpc_pkg::WAKE_PME]  = !pme_n_i;
    wake_raw[swpc_pkg::WAKE_LAN]  = lan_wake_i;
    wake_raw[swpc_pkg::WAKE_BTN]  = btn_short;
  end

  // Per-source eligibility by current sleep state
  always_comb
  begin
    wake_en = '0;
    wake_en[swpc_pkg::WAKE_RING] = in_s1s3 &&
      ctrl_reg[swpc_pkg::CTRL_RING_UNMASK];
    wake_en[swpc_pkg::WAKE_USB]  = in_s1s3;
    wake_en[swpc_pkg::WAKE_PS2]  = in_s1s3;
    wake_en[swpc_pkg::WAKE_PME]  = ctrl_reg[swpc_pkg::CTRL_PME_EN] &&
      (!in_s5ish || ctrl_reg[swpc_pkg::CTRL_S5_WAKE_EN]) &&
      sleeping;
    wake_en[swpc_pkg::WAKE_LAN]  = sleeping &&
      (!in_s5ish || ctrl_reg[swpc_pkg::CTRL_S5_WAKE_EN]);
    wake_en[swpc_pkg::WAKE_BTN]  = sleeping;
  end

  // Sticky latches; a single pulse is enough, no repeat needed
  genvar gi;
  generate
    for (gi = 0; gi < swpc_pkg::NWAKE; gi++)
    begin : g_wake
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_i)
          wake_reg[gi] <= 1'b0;
        else if (wake_raw[gi] && wake_en[gi])
          wake_reg[gi] <= 1'b1;
        else if (state_reg == swpc_pkg::SWPC_S0 && main_pwr_good_i)
          wake_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  assign wake_any = |wake_reg;

  // Power switch hold timer
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      btn_reg      <= 1'b0;
      hold_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      btn_reg <= pwr_button_i;
      if (!pwr_button_i)
        hold_cnt_reg <= 32'h0000_0000;
      else if (hold_cnt_reg <= HOLD_CYCLES[31:0])
        hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
    end
  end

  // Release before the limit is a short press
  assign btn_short = btn_reg && !pwr_button_i &&
                     hold_cnt_reg <= HOLD_CYCLES[31:0];
  assign failsafe  = pwr_button_i && hold_cnt_reg == HOLD_CYCLES[31:0];

  // Sleep state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      swpc_pkg::SWPC_S0:
      begin
        if (failsafe)
          state_next = swpc_pkg::SWPC_S5;
        else if (ctrl_reg[swpc_pkg::CTRL_OFF_REQ] || btn_short)
          state_next = swpc_pkg::SWPC_S5;
        else if (ctrl_reg[swpc_pkg::CTRL_SLEEP_REQ])
        begin
          if (ctrl_reg[swpc_pkg::CTRL_S4])
            state_next = swpc_pkg::SWPC_S4;
          else if (ctrl_reg[swpc_pkg::CTRL_S3])
            state_next = swpc_pkg::SWPC_S3;
          else
            state_next = swpc_pkg::SWPC_S1;
        end
      end
      swpc_pkg::SWPC_S1, swpc_pkg::SWPC_S3,
      swpc_pkg::SWPC_S4, swpc_pkg::SWPC_S5:
      begin
        if (failsafe)
          state_next = swpc_pkg::SWPC_S5;
        else if (wake_any)
          state_next = swpc_pkg::SWPC_S0;
      end
      swpc_pkg::SWPC_MECH:
      begin
        if (main_pwr_good_i)
        begin
          if (policy == swpc_pkg::POLICY_ON ||
              (policy == swpc_pkg::POLICY_LAST && was_on_reg))
            state_next = swpc_pkg::SWPC_S0;
          else
            state_next = swpc_pkg::SWPC_S5;
        end
      end
      default:
        state_next = swpc_pkg::SWPC_S5;
    endcase
    if (pwr_lost && state_reg != swpc_pkg::SWPC_S3 &&
        state_reg != swpc_pkg::SWPC_S1)
      state_next = swpc_pkg::SWPC_MECH;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_reg  <= swpc_pkg::SWPC_MECH;
      was_on_reg <= 1'b0;
      pg_reg     <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pg_reg    <= main_pwr_good_i;
      // Remember on/off only while power is solid
      if (state_reg != swpc_pkg::SWPC_MECH && main_pwr_good_i)
        was_on_reg <= state_reg == swpc_pkg::SWPC_S0 ||
                      state_reg == swpc_pkg::SWPC_S1;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      supply_on_o      <= 1'b0;
      cpu_fan_on_o     <= 1'b0;
      chassis_fan_on_o <= 1'b0;
      led_green_o      <= 1'b0;
      led_amber_o      <= 1'b0;
      standby_led_o    <= 1'b0;
    end
    else
    begin
      supply_on_o      <= state_next == swpc_pkg::SWPC_S0 ||
                          state_next == swpc_pkg::SWPC_S1;
      cpu_fan_on_o     <= state_next == swpc_pkg::SWPC_S0 ||
                          state_next == swpc_pkg::SWPC_S1;
      chassis_fan_on_o <= state_next == swpc_pkg::SWPC_S0 ||
                          state_next == swpc_pkg::SWPC_S1;
      led_green_o      <= state_next == swpc_pkg::SWPC_S0;
      led_amber_o      <= state_next == swpc_pkg::SWPC_S3 &&
                          ctrl_reg[swpc_pkg::CTRL_DUAL_LED];
      standby_led_o    <= standby_present_i;
    end
  end

  // Control register; request bits self-clear once acted on
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      ctrl_reg <= swpc_pkg::CTRL_RESET;
    else if (wr_i && addr_i == swpc_pkg::ADDR_CTRL)
      ctrl_reg <= {20'h0_0000, wdata_i[11:0]};
    else if (state_reg != state_next)
    begin
      ctrl_reg[swpc_pkg::CTRL_SLEEP_REQ] <= 1'b0;
      ctrl_reg[swpc_pkg::CTRL_OFF_REQ]   <= 1'b0;
    end
  end

  // Interrupt events: wake taken, fail-safe off, outage restore
  assign irq_set[swpc_pkg::IRQ_WAKE]     = sleeping &&
    state_next == swpc_pkg::SWPC_S0;
  assign irq_set[swpc_pkg::IRQ_FAILSAFE] = failsafe;
  assign irq_set[swpc_pkg::IRQ_RESTORE]  = pwr_back;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end
    else
    begin
      if (wr_i && addr_i == swpc_pkg::ADDR_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~wdata_i[2:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
      if (wr_i && addr_i == swpc_pkg::ADDR_IRQ_MASK)
        irq_mask_reg <= wdata_i[2:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  // Read port, data one cycle after strobe, zero when unmapped
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
    begin
      case (addr_i)
        swpc_pkg::ADDR_CTRL:
          rdata_o <= {irq_mask_reg, 17'h0_0000, ctrl_reg[11:0]};
        swpc_pkg::ADDR_STATE:
          rdata_o <= {28'h000_0000, was_on_reg, state_reg};
        swpc_pkg::ADDR_WAKE:
          rdata_o <= {26'h000_0000, wake_reg};
        swpc_pkg::ADDR_IRQ_STAT:
          rdata_o <= {29'h0000_0000, irq_stat_reg};
        default:
          rdata_o <= 32'h0000_0000;
      endcase
    end
    else
      rdata_o <= 32'h0000_0000;
  end
endmodule

// ---- tb/swpc_assertions.sv ----
// Port checker for the sleep and wake power controller.
// Assumes binding onto swpc_top, one clock, sync reset.
`timescale 1ns/1ps
module swpc_assertions #(
  parameter int HOLD_CYCLES = swpc_pkg::HOLD_CYCLES
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        main_pwr_good_i,
  input wire logic        standby_present_i,
  input wire logic        usb_activity_i,
  input wire logic        ps2_activity_i,
  input wire logic        pwr_button_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        supply_on_o,
  input wire logic        cpu_fan_on_o,
  input wire logic        chassis_fan_on_o,
  input wire logic        led_green_o,
  input wire logic        led_amber_o,
  input wire logic        standby_led_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Saturates so a stuck switch never wraps back to zero
  logic [31:0] hold_cnt_reg;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !pwr_button_i)
      hold_cnt_reg <= 32'h0000_0000;
    else if (hold_cnt_reg != 32'hffff_ffff)
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
  end
  fan_pair_a:
  assert property (cpu_fan_on_o == chassis_fan_on_o)
    else $error("fan outputs differ");
  fan_supply_a:
  assert property (cpu_fan_on_o |-> supply_on_o)
    else $error("fan on without supply");
  amber_dark_a:
  assert property (led_amber_o |-> !supply_on_o && !cpu_fan_on_o)
    else $error("amber with power on");
  green_lit_a:
  assert property (led_green_o |-> supply_on_o && !led_amber_o)
    else $error("green without supply");
  standby_copy_a:
  assert property (!$past(rst_i) |->
    standby_led_o == $past(standby_present_i))
    else $error("standby led wrong");
  rdata_idle_a:
  assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside slot");
  supply_rise_a:
  assert property ($rose(supply_on_o) |-> $past(main_pwr_good_i))
    else $error("supply on without mains");
  usb_wake_a:
  assert property (led_amber_o && usb_activity_i |-> ##[1:3] supply_on_o)
    else $error("usb wake missed");
  ps2_wake_a:
  assert property (led_amber_o && ps2_activity_i |-> ##[1:3] supply_on_o)
    else $error("ps2 wake missed");
  hold_off_a:
  assert property (hold_cnt_reg > HOLD_CYCLES + 4 |-> !supply_on_o)
    else $error("held switch kept power");
  cover property (led_amber_o && usb_activity_i);
  cover property (hold_cnt_reg > HOLD_CYCLES + 4);
  cover property ($fell(main_pwr_good_i));
endmodule

// ---- tb/swpc_supply_model.sv ----
// Mains, standby rail and remote-on main supply.
// Assumes the bench drives ac_on_i off the clock edge.
`timescale 1ns/1ps
module swpc_supply_model (
  input  wire logic sys_clk_i,
  input  wire logic ac_on_i,
  input  wire logic supply_on_i,
  output logic      pwr_good_o,
  output logic      standby_o,
  output logic      rail_o
);
  always_ff @(posedge sys_clk_i)
  begin
    pwr_good_o <= ac_on_i;
    standby_o  <= ac_on_i;
    rail_o     <= ac_on_i & supply_on_i;
  end
endmodule

// ---- tb/tb.sv ----
// Bench for swpc_top: register port, wake sources, mains.
// Assumes HOLD_CYCLES shortened to 50.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ac = 1'b1;
  logic        btn = 1'b0;
  logic [5:0]  src = 6'h00;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        pg, sb, rail, sup, cf, chf, grn, amb, sbl, irq;
  int          errors = 0;
  int          n_tests = 0;
  logic [5:0]  wk [5] = '{6'h01, 6'h20, 6'h02, 6'h04, 6'h06};
  always #2.5 clk = ~clk;
  swpc_supply_model i_swpc_supply_model (.sys_clk_i(clk), .ac_on_i(ac),
    .supply_on_i(sup), .pwr_good_o(pg), .standby_o(sb), .rail_o(rail));
  swpc_top #(.HOLD_CYCLES(50)) i_swpc_top (.sys_clk_i(clk), .rst_i(rst),
    .main_pwr_good_i(pg), .standby_present_i(sb), .ring_ext_i(src[0]),
    .ring_int_i(src[5]), .usb_activity_i(src[1]),
    .ps2_activity_i(src[2]), .pme_n_i(~src[3]), .lan_wake_i(src[4]),
    .pwr_button_i(btn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .supply_on_o(sup), .cpu_fan_on_o(cf),
    .chassis_fan_on_o(chf), .led_green_o(grn), .led_amber_o(amb),
    .standby_led_o(sbl), .irq_o(irq));
  task test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Polls the state register, bounded, then compares
  task st(input logic [2:0] e);
    logic [31:0] v;
    for (int i = 0; i < 30; i++)
    begin
      rd_reg(4'h4, v);
      if (v[2:0] === e)
        break;
    end
    chk({29'h0, v[2:0]}, {29'h0, e});
  endtask
  task pulse(input logic [5:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 6'h00;
    repeat (4) @(posedge clk);
  endtask
  task press;
    @(posedge clk);
    btn <= 1'b1;
    repeat (3) @(posedge clk);
    btn <= 1'b0;
  endtask
  task clr;
    wr_reg(4'hc, 32'h0000_0007);
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    logic [31:0] v;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    st(swpc_pkg::SWPC_S5);
    chk({cf, chf, sup, sbl}, 4'h1);
    rd_reg(4'h2, v);
    chk(v, 32'h0000_0000);
    press();
    st(swpc_pkg::SWPC_S0);
    chk({grn, cf, chf, sup, sbl}, 5'h1f);
    wr_reg(swpc_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    clr();
    chk(irq, 1'b0);
    wr_reg(4'h0, 32'h0000_0241);
    st(swpc_pkg::SWPC_S3);
    chk({grn, sup, amb, cf}, 4'h2);
    pulse(6'h20);
    st(swpc_pkg::SWPC_S3);
    wr_reg(4'h0, 32'h0000_0a40);
    pulse(6'h20);
    st(swpc_pkg::SWPC_S0);
    chk(irq, 1'b1);
    wr_reg(swpc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    clr();
    pulse(6'h01);
    st(swpc_pkg::SWPC_S0);
    foreach (wk[i])
    begin
      wr_reg(4'h0, 32'h0000_0a41);
      st(swpc_pkg::SWPC_S3);
      pulse(wk[i]);
      st(swpc_pkg::SWPC_S0);
    end
    chk(irq, 1'b0);
    wr_reg(swpc_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    clr();
    chk(irq, 1'b0);
    wr_reg(4'h0, 32'h0000_0445);
    st(swpc_pkg::SWPC_S4);
    pulse(6'h02);
    st(swpc_pkg::SWPC_S4);
    pulse(6'h08);
    st(swpc_pkg::SWPC_S0);
    wr_reg(4'h0, 32'h0000_0006);
    st(swpc_pkg::SWPC_S5);
    chk(rail, 1'b0);
    pulse(6'h10);
    st(swpc_pkg::SWPC_S5);
    pulse(6'h08);
    st(swpc_pkg::SWPC_S5);
    wr_reg(4'h0, 32'h0000_000c);
    pulse(6'h10);
    st(swpc_pkg::SWPC_S0);
    @(posedge clk);
    btn <= 1'b1;
    repeat (60) @(posedge clk);
    btn <= 1'b0;
    st(swpc_pkg::SWPC_S5);
    press();
    st(swpc_pkg::SWPC_S0);
    @(posedge clk);
    ac <= 1'b0;
    st(swpc_pkg::SWPC_MECH);
    chk({sbl, grn, sup, cf}, 4'h0);
    @(posedge clk);
    ac <= 1'b1;
    st(swpc_pkg::SWPC_S0);
    wr_reg(4'h0, 32'h0000_0020);
    @(posedge clk);
    ac <= 1'b0;
    st(swpc_pkg::SWPC_MECH);
    @(posedge clk);
    ac <= 1'b1;
    st(swpc_pkg::SWPC_S5);
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule
bind swpc_top swpc_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (
  .sys_clk_i, .rst_i, .main_pwr_good_i, .standby_present_i,
  .usb_activity_i, .ps2_activity_i, .pwr_button_i, .rd_i, .rdata_o,
  .supply_on_o, .cpu_fan_on_o, .chassis_fan_on_o, .led_green_o,
  .led_amber_o, .standby_led_o);
